/* File: logic/pvtr_map.svh */
// Address, field and reset constants for the program vector and table read block.
// How it works
// R1: Flash holds 8K words, 0000H to 1FFFH.
// R2: One reset vector word at 0000H.
// R3: Any reset refetches 0000H, registers default.
// R4: Reset cause sets power-down and time-out flags.
// R5: Interrupt pushes counter, fetches from 0004H.
// R6: All interrupt sources share one entry.
// R7: No automatic save of working or status.
// R8: Table read to register: low byte out.
// R9: Table read to accumulator: low byte to working.
// R10: Any flash address may be a table source.
// R11: Address high register at 110H, five bits used.
// R12: Address low register at 111H, eight bits.
// R13: Result high byte at 112H, read-only.
// R14: Software loads address, masks interrupts around lookups.
// R15: Table address is high[4:0] joined to low.
`ifndef PVTR_MAP_SVH
`define PVTR_MAP_SVH
`define PVTR_ADDR_W 13
`define PVTR_RESET_VEC 13'h0000
`define PVTR_INT_VEC 13'h0004
`define PVTR_LAST_ADDR 13'h1FFF
`define PVTR_REG_TAH 9'h110
`define PVTR_REG_TAL 9'h111
`define PVTR_REG_TRH 9'h112
`define PVTR_REG_CTL 9'h113
`define PVTR_REG_STAT 9'h114
`define PVTR_REG_PCL 9'h115
`define PVTR_REG_PCH 9'h116
`define PVTR_REG_WORK 9'h117
`define PVTR_REG_DEST 9'h118
`define PVTR_REG_DLOW 9'h119
`define PVTR_STACK_DEPTH 8
`define PVTR_SP_W 3
`define PVTR_CTL_RD_REG 0
`define PVTR_CTL_RD_ACC 1
`define PVTR_CTL_INT 2
`define PVTR_CTL_RET 3
`define PVTR_CTL_STEP 4
`define PVTR_CTL_RST_WDT 5
`define PVTR_CTL_RST_LVR 6
`define PVTR_STAT_PD 0
`define PVTR_STAT_TO 1
`define PVTR_STAT_BUSY 2
`endif

/* File: logic/pvtr_pkg.sv */
// Types shared by the program vector and table read block.
package pvtr_pkg;
  typedef enum logic [1:0] {
    PVTR_RST_POWER,
    PVTR_RST_WDT,
    PVTR_RST_LVR
  } pvtr_reset_kind_type;
  typedef enum logic [1:0] {
    PVTR_IDLE,
    PVTR_FETCH,
    PVTR_STORE
  } pvtr_state_type;
endpackage

/* File: logic/pvtr_sync.sv */
// Three-stage synchroniser for a pin that comes from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module pvtr_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/pvtr_top.sv */
// Program counter vectors, return stack and table-read engine with a Wishbone slave.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pvtr_map.svh"
module pvtr_top
  import pvtr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wdt_reset_i,
  input wire logic lvr_reset_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [12:0] flash_addr_o,
  output logic flash_rd_o,
  input wire logic [15:0] flash_data_i,
  input wire logic flash_valid_i,
  output logic [12:0] program_counter_o,
  output logic [7:0] dest_wr_addr_o,
  output logic [7:0] dest_wr_data_o,
  output logic dest_wr_o,
  output logic sys_reset_o
);
  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  logic wdt_level;
  logic lvr_level;
  logic wdt_prev;
  logic lvr_prev;
  logic wdt_evt;
  logic lvr_evt;
  pvtr_sync u_wdt_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(wdt_reset_i),
    .level_o(wdt_level)
  );
  pvtr_sync u_lvr_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(lvr_reset_i),
    .level_o(lvr_level)
  );
  // Only a rising edge acts, so a pin held high resets the block once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_prev <= 1'b0;
    end else begin
      wdt_prev <= wdt_level;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvr_prev <= 1'b0;
    end else begin
      lvr_prev <= lvr_level;
    end
  end
  logic sw_wdt;
  logic sw_lvr;
  assign wdt_evt = (wdt_level & ~wdt_prev) | sw_wdt;
  assign lvr_evt = (lvr_level & ~lvr_prev) | sw_lvr;
  // Any of the three resets returns the block's system state to default.
  logic soft_rst;
  assign soft_rst = rst_i | wdt_evt | lvr_evt; // [R3]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= wdt_evt | lvr_evt;
    end
  end
  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Power-on sets both flags; a watchdog reset clears time-out only,
  // a low-voltage reset behaves like power-on. Software reads them.
  logic power_down_flag;
  logic time_out_flag;
  // Nothing here models sleep, so the power-down flag only ever reads one.
  always_ff @(posedge clk_i) begin
    if (rst_i || wdt_evt || lvr_evt) begin
      power_down_flag <= 1'b1; // [R4]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_out_flag <= 1'b1; // [R4]
    end else if (wdt_evt) begin
      time_out_flag <= 1'b0; // [R4]
    end else if (lvr_evt) begin
      time_out_flag <= 1'b1; // [R4]
    end
  end
  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic wr_lo;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign wr_lo = wr & wb_sel_i[0];
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] table_address_high;
  logic [7:0] table_address_low;
  logic [7:0] table_result_high_byte;
  logic [7:0] working_register;
  logic [7:0] dest_reg;
  logic [7:0] last_low;
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      table_address_high <= 8'h00;
    end else if (wr_lo && wb_adr_i == `PVTR_REG_TAH) begin
      table_address_high <= wb_dat_i[7:0]; // [R11]
    end
  end
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      table_address_low <= 8'h00;
    end else if (wr_lo && wb_adr_i == `PVTR_REG_TAL) begin
      table_address_low <= wb_dat_i[7:0]; // [R12]
    end
  end
  // Destination register index used by the read-to-register form.
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      dest_reg <= 8'h00;
    end else if (wr_lo && wb_adr_i == `PVTR_REG_DEST) begin
      dest_reg <= wb_dat_i[7:0];
    end
  end
  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  // The stack holds only the counter; working and status registers
  // are left to software, since no push or pop of context exists.
  logic [12:0] program_counter;
  logic [12:0] stack_mem [0:`PVTR_STACK_DEPTH-1];
  logic [`PVTR_SP_W-1:0] sp;
  logic ctl_int;
  logic ctl_ret;
  logic ctl_step;
  logic [12:0] pc_load_val;
  logic pc_load_lo;
  logic pc_load_hi;
  // ----------------------------------------------------------------
  // Control strobes
  // ----------------------------------------------------------------
  // Several strobes may share one write; a soft reset strobe wins, then interrupt entry.
  assign ctl_int = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_INT];
  assign ctl_ret = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_RET];
  assign ctl_step = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_STEP];
  assign sw_wdt = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_RST_WDT];
  assign sw_lvr = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_RST_LVR];
  assign pc_load_lo = wr_lo && wb_adr_i == `PVTR_REG_PCL;
  assign pc_load_hi = wr_lo && wb_adr_i == `PVTR_REG_PCH;
  assign pc_load_val = pc_load_lo ? {program_counter[12:8], wb_dat_i[7:0]}
                                  : {wb_dat_i[4:0], program_counter[7:0]};
  // The stack is written only on entry; its words need no reset since
  // the pointer alone decides which of them are live.
  always_ff @(posedge clk_i) begin
    if (!soft_rst && ctl_int) begin
      stack_mem[sp] <= program_counter; // [R5]
    end
  end
  // No overflow check: a ninth nested entry overwrites the oldest word.
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      sp <= '0;
    end else if (ctl_int) begin
      sp <= sp + 1'b1;
    end else if (ctl_ret) begin
      sp <= sp - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      program_counter <= `PVTR_RESET_VEC; // [R2] [R3]
    end else if (ctl_int) begin
      // Every source lands on one entry; software polls request flags.
      program_counter <= `PVTR_INT_VEC; // [R5] [R6] [R7]
    end else if (ctl_ret) begin
      program_counter <= stack_mem[sp - 1'b1];
    end else if (pc_load_lo || pc_load_hi) begin
      program_counter <= pc_load_val;
    end else if (ctl_step) begin
      // Counter wraps from 1FFFH back to 0000H within 8K words.
      program_counter <= program_counter + 13'h0001; // [R1]
    end
  end
  // The exported counter lags the internal one by a cycle so that it stays a flop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_counter_o <= `PVTR_RESET_VEC;
    end else begin
      program_counter_o <= program_counter;
    end
  end
  // ----------------------------------------------------------------
  // Table read engine
  // ----------------------------------------------------------------
  // Whole 13-bit space is reachable; only the low five high-bits count.
  logic [12:0] table_addr;
  assign table_addr = {table_address_high[4:0], table_address_low}; // [R15] [R10]
  pvtr_state_type state;
  logic to_acc;
  logic rd_reg_req;
  logic rd_acc_req;
  logic start_rd;
  logic answer;
  logic store_acc;
  logic store_dest;
  assign rd_reg_req = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_RD_REG];
  assign rd_acc_req = wr_lo && wb_adr_i == `PVTR_REG_CTL && wb_dat_i[`PVTR_CTL_RD_ACC];
  // A start that arrives while a read is in flight is dropped, not queued,
  // so software must poll the busy bit before the next lookup.
  assign start_rd = (state == PVTR_IDLE) && (rd_reg_req || rd_acc_req);
  assign answer = (state == PVTR_FETCH) && flash_valid_i;
  assign store_acc = (state == PVTR_STORE) && to_acc;
  assign store_dest = (state == PVTR_STORE) && !to_acc;
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      state <= PVTR_IDLE;
    end else begin
      unique case (state)
        PVTR_IDLE: begin
          if (start_rd) begin
            state <= PVTR_FETCH;
          end
        end
        PVTR_FETCH: begin
          if (answer) begin
            state <= PVTR_STORE;
          end
        end
        PVTR_STORE: begin
          state <= PVTR_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      to_acc <= 1'b0;
    end else if (start_rd) begin
      to_acc <= rd_acc_req;
    end
  end
  // The request holds until the array answers; a slow array only stretches busy.
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      flash_rd_o <= 1'b0;
      flash_addr_o <= `PVTR_RESET_VEC;
    end else if (start_rd) begin
      flash_rd_o <= 1'b1;
      flash_addr_o <= table_addr;
    end else if (answer) begin
      flash_rd_o <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      table_result_high_byte <= 8'h00;
      last_low <= 8'h00;
    end else if (answer) begin
      table_result_high_byte <= flash_data_i[15:8]; // [R8] [R9] [R13]
      last_low <= flash_data_i[7:0];
    end
  end
  // ----------------------------------------------------------------
  // Result delivery
  // ----------------------------------------------------------------
  // A completing lookup wins over a bus write to the working register.
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      working_register <= 8'h00;
    end else if (store_acc) begin
      working_register <= last_low; // [R9]
    end else if (wr_lo && wb_adr_i == `PVTR_REG_WORK) begin
      working_register <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      dest_wr_o <= 1'b0;
      dest_wr_addr_o <= 8'h00;
      dest_wr_data_o <= 8'h00;
    end else begin
      dest_wr_o <= store_dest; // [R8]
      if (store_dest) begin
        dest_wr_addr_o <= dest_reg; // [R8]
        dest_wr_data_o <= last_low; // [R8]
      end
    end
  end
  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (wb_adr_i)
      `PVTR_REG_TAH: next_rdata = table_address_high; // [R11]
      `PVTR_REG_TAL: next_rdata = table_address_low; // [R12]
      `PVTR_REG_TRH: next_rdata = table_result_high_byte; // [R13]
      `PVTR_REG_STAT: next_rdata = {5'h00, state != PVTR_IDLE,
                                     time_out_flag, power_down_flag}; // [R4]
      `PVTR_REG_PCL: next_rdata = program_counter[7:0];
      `PVTR_REG_PCH: next_rdata = {3'h0, program_counter[12:8]};
      `PVTR_REG_WORK: next_rdata = working_register;
      `PVTR_REG_DEST: next_rdata = dest_reg;
      `PVTR_REG_DLOW: next_rdata = last_low;
      default: next_rdata = 8'h00;
    endcase
  end
  // Unmapped addresses still ack and read as zero so the bus never hangs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end
  // Data is refreshed every cycle; the master only looks while ack stands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= {24'h000000, next_rdata};
    end
  end
endmodule
`default_nettype wire

/* File: test/pvtr_flash_model.sv */
// Behavioural flash array that answers table reads promptly or slowly.
`timescale 1ns/100ps
`default_nettype none
module pvtr_flash_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic rd_i,
  input wire logic [12:0] addr_i,
  output logic [15:0] data_o,
  output logic valid_o
);
  logic [2:0] wait_cnt = 3'h0;
  initial valid_o = 1'b0;
  initial data_o = 16'h0000;
  // Data toggles between answers so a late sample never matches by luck.
  always @(posedge clk_i) begin
    if (rd_i && !valid_o && wait_cnt >= (slow_i ? 3'h4 : 3'h0)) begin
      valid_o <= 1'b1;
      data_o <= {addr_i[7:0] ^ 8'h3C, 3'h0, addr_i[12:8]};
      wait_cnt <= 3'h0;
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
      wait_cnt <= rd_i ? wait_cnt + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

/* File: test/pvtr_top_checker.sv */
// Checker for vectors, table address and table-read handshakes.
`timescale 1ns/100ps
`default_nettype none
module pvtr_top_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [12:0] flash_addr_o,
  input wire logic flash_rd_o,
  input wire logic [15:0] flash_data_i,
  input wire logic flash_valid_i,
  input wire logic [12:0] program_counter_o,
  input wire logic [7:0] dest_wr_data_o,
  input wire logic dest_wr_o,
  input wire logic sys_reset_o
);
  logic [7:0] tah, tal, lo_q;
  logic to_dest, int_q, wr;
  assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  // Shadows follow the bus so the table address can be predicted.
  always_ff @(posedge clk_i) begin
    int_q <= wr && wb_adr_i == 9'h113 && wb_dat_i[2];
    if (flash_rd_o && flash_valid_i) lo_q <= flash_data_i[7:0];
    if (wr && wb_adr_i == 9'h113 && wb_dat_i[1:0] != 2'h0) to_dest <= wb_dat_i[0];
    if (rst_i || sys_reset_o) begin
      tah <= 8'h00;
      tal <= 8'h00;
    end else if (wr && wb_adr_i == 9'h110) tah <= wb_dat_i[7:0];
    else if (wr && wb_adr_i == 9'h111) tal <= wb_dat_i[7:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_answer;
    flash_rd_o && flash_valid_i;
  endsequence
  sequence s_store;
    ##[1:2] (dest_wr_o && dest_wr_data_o == lo_q);
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too wide");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_pc_reset: assert property ($fell(sys_reset_o) |-> program_counter_o == 13'h0000)
    else $error("pc not at reset vector");
  a_int_vector: assert property (int_q |-> ##[0:1] program_counter_o == 13'h0004)
    else $error("pc not at interrupt vector");
  a_table_addr: assert property ($rose(flash_rd_o) |-> flash_addr_o == {tah[4:0], tal})
    else $error("wrong table address");
  a_rd_hold: assert property (flash_rd_o && !flash_valid_i |=> flash_rd_o && $stable(flash_addr_o))
    else $error("read dropped early");
  a_rd_drop: assert property (s_answer |=> !flash_rd_o)
    else $error("read held after answer");
  a_dest_store: assert property (s_answer ##0 to_dest |-> s_store)
    else $error("low byte not written");
  a_acc_no_dest: assert property (s_answer ##0 !to_dest |=> !dest_wr_o [*2])
    else $error("stray register write");
endmodule
bind pvtr_top pvtr_top_checker u_checker (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .flash_addr_o, .flash_rd_o, .flash_data_i, .flash_valid_i,
  .program_counter_o, .dest_wr_data_o, .dest_wr_o, .sys_reset_o);
`default_nettype wire

/* File: test/pvtr_top_bench.sv */
// Self-checking bench for the program vector and table read block.
`timescale 1ns/100ps
`default_nettype none
module pvtr_top_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, wdt = 1'b0, low_voltage_reset = 1'b0, we = 1'b0, cyc = 1'b0, slow = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [7:0] wd = 8'h00, q;
  logic [31:0] rdat;
  logic ack, frd, fval;
  logic [12:0] fadr;
  logic [15:0] fdat;
  logic [7:0] dwa, dwd;
  logic dwr;
  logic [15:0] dcap = 16'h0000;
  logic [12:0] tbl [4] = '{13'h0000, 13'h1FFF, 13'h0602, 13'h0A5A};
  int miscompares = 0, tests_run = 0;
  always #20 clk_i = ~clk_i;
  pvtr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wdt_reset_i(wdt), .lvr_reset_i(low_voltage_reset),
    .wb_adr_i(adr), .wb_dat_i({24'h000000, wd}), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(fadr), .flash_rd_o(frd),
    .flash_data_i(fdat), .flash_valid_i(fval), .program_counter_o(), .dest_wr_addr_o(dwa),
    .dest_wr_data_o(dwd), .dest_wr_o(dwr), .sys_reset_o());
  pvtr_flash_model flash (.clk_i(clk_i), .slow_i(slow), .rd_i(frd), .addr_i(fadr),
    .data_o(fdat), .valid_o(fval));
  // Keep the last destination write so lookups can check its address and data.
  always @(posedge clk_i) if (dwr) dcap <= {dwa, dwd};
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [8:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wd <= d;
    cyc <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask
  task automatic lookup(input logic [12:0] a, input logic acc);
    int n;
    n = 0;
    bus(9'h110, 1'b1, {3'h7, a[12:8]});
    bus(9'h111, 1'b1, a[7:0]);
    bus(9'h113, 1'b1, acc ? 8'h02 : 8'h01);
    do begin
      bus(9'h114, 1'b0, 8'h00);
      n++;
    end while (q[2] !== 1'b0 && n < 20);
    if (q[2] !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
    rd(9'h112, a[7:0] ^ 8'h3C);
    rd(acc ? 9'h117 : 9'h119, {3'h0, a[12:8]});
    if (!acc) chk(dcap[15:8], 8'h42);
    if (!acc) chk(dcap[7:0], {3'h0, a[12:8]});
  endtask
  // The reset pins pass a synchroniser, so the pulse is stretched and then allowed to settle.
  task automatic pin_reset(input logic dog);
    @(posedge clk_i);
    wdt <= dog;
    low_voltage_reset <= !dog;
    repeat (4) @(posedge clk_i);
    wdt <= 1'b0;
    low_voltage_reset <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(9'h114, 8'h03);
    rd(9'h115, 8'h00);
    bus(9'h110, 1'b1, 8'hFF);
    bus(9'h111, 1'b1, 8'hFF);
    bus(9'h112, 1'b1, 8'h55);
    rd(9'h110, 8'hFF);
    rd(9'h111, 8'hFF);
    rd(9'h112, 8'h00);
    rd(9'h1FF, 8'h00);
    $display("test registers done");
    bus(9'h118, 1'b1, 8'h42);
    foreach (tbl[i]) begin
      slow <= i[0];
      lookup(tbl[i], i[1]);
    end
    $display("test lookups done");
    bus(9'h115, 1'b1, 8'h34);
    bus(9'h116, 1'b1, 8'h12);
    bus(9'h117, 1'b1, 8'h77);
    bus(9'h113, 1'b1, 8'h04);
    rd(9'h115, 8'h04);
    rd(9'h116, 8'h00);
    rd(9'h117, 8'h77);
    bus(9'h113, 1'b1, 8'h08);
    rd(9'h115, 8'h34);
    rd(9'h116, 8'h12);
    $display("test interrupt done");
    bus(9'h113, 1'b1, 8'h20);
    rd(9'h114, 8'h01);
    rd(9'h116, 8'h00);
    bus(9'h115, 1'b1, 8'hFF);
    bus(9'h116, 1'b1, 8'h1F);
    bus(9'h113, 1'b1, 8'h10);
    rd(9'h115, 8'h00);
    rd(9'h116, 8'h00);
    bus(9'h113, 1'b1, 8'h40);
    rd(9'h114, 8'h03);
    $display("test step and soft resets done");
    pin_reset(1'b1);
    rd(9'h114, 8'h01);
    rd(9'h115, 8'h00);
    rd(9'h110, 8'h00);
    bus(9'h115, 1'b1, 8'h10);
    pin_reset(1'b0);
    rd(9'h114, 8'h03);
    rd(9'h115, 8'h00);
    $display("test resets done");
    end_of_test();
  end
endmodule
`default_nettype wire
